// *** rtl/ccs_pkg.sv ***
// constants for the clock source switch and reference clock output
// assumes a single core clock; oscillators arrive as raw pin levels
`default_nettype none
package ccs_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [1:0] CCS_OFS_OSC_CTRL = 2'h0;
  localparam logic [1:0] CCS_OFS_AUX = 2'h1;
  localparam logic [1:0] CCS_OFS_STATUS = 2'h2;
  localparam int CCS_IDLE_BIT = 7;
  localparam int CCS_STARTUP_TIMEOUT_STATUS_BIT = 3;
  localparam int CCS_UNUSED_BIT = 2;
  localparam int CCS_RO_EN_BIT = 7;
  localparam int CCS_RO_SLP_BIT = 5;
  localparam int CCS_RO_SRC_BIT = 4;
  localparam int CCS_AUX_LFS_BIT = 0;
  localparam int CCS_AUX_SEC_EN_BIT = 1;
  localparam int CCS_AUX_ALT_BIT = 4;
  localparam logic [2:0] CCS_IFS_RESET = 3'h6;
  localparam logic [2:0] CCS_IFS_LOW = 3'h0;
  localparam logic [2:0] CCS_CFG_INT_A = 3'h0;
  localparam logic [2:0] CCS_CFG_INT_B = 3'h1;
  // ****************************************
  // switch timing, in ticks of the sources
  // ****************************************
  localparam logic [1:0] CCS_OLD_TICKS = 2'h2;
  localparam logic [1:0] CCS_NEW_TICKS = 2'h3;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    CCS_SRC_PRI = 2'b00,
    CCS_SRC_SEC = 2'b01,
    CCS_SRC_RSVD = 2'b10,
    CCS_SRC_INT = 2'b11
  } ccs_src_type;
  typedef enum logic [1:0] {
    CCS_SW_RUN = 2'b00,
    CCS_SW_OLD = 2'b01,
    CCS_SW_NEW = 2'b10
  } ccs_sw_type;
  typedef enum logic [1:0] {
    CCS_PWR_ACTIVE = 2'b00,
    CCS_PWR_IDLE = 2'b01,
    CCS_PWR_SLEEP = 2'b10
  } ccs_pwr_type;
endpackage
`default_nettype wire

// *** rtl/ccs_clock_switch.sv ***
// clock source selection, internal postscaler, glitch-free switch
// and divided reference clock output, all as core_clk enables
// assumes oscillator pins are slower than core_clk / 4
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - select 11 internal, 01 secondary, 00 primary
// - any reset clears select to primary
// - select write starts switch at once
// - frequency field maps eight postscaler rates
// - new frequency applies immediately when internal
// - reset sets postscaler to 4 MHz
// - field 000 picks fast/256 or slow osc
// - watchdog always clocked from slow osc
// - startup status set when primary timer expired
// - secondary running flag exclusive with startup status
// - sleep enters idle or full sleep
// - secondary select ignored unless oscillator enabled
// - pause two old plus three new ticks
// - primary uses postscaler for config 000/001
// - startup status resets to zero, then follows timer and two-speed strap
// - unused oscillator bit 2 reads one
// - alternate select swaps in reference register
// - output enable bit drives reference pin
// - divide base clock by two to the field
// - base is primary or current system clock
// - reference runs in sleep only if allowed
module ccs_clock_switch (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // oscillator and strap pins
  input wire logic primary_osc,
  input wire logic secondary_osc,
  input wire logic fast_internal_osc,
  input wire logic slow_internal_osc,
  input wire logic startup_timer_done,
  input wire logic two_speed_enable,
  input wire logic [2:0] oscillator_config_field,
  // power commands from the core
  input wire logic sleep_cmd,
  input wire logic wake_cmd,
  // clock enables and status
  output logic sys_clk_en,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic watchdog_clk_en,
  output var ccs_pkg::ccs_src_type active_source,
  // reference clock pin
  output logic refout_pin,
  output logic refout_pin_oe_b
);
  import ccs_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // a change counts only when the second and third stages agree
  logic [8:0] sync1, sync2, sync3, filt;
  logic [8:0] next_filt;
  assign next_filt = (sync2 & sync3) | ((sync2 ^ sync3) & filt);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {sync1, sync2, sync3, filt} <= 36'h0;
    end else begin
      sync1 <= {oscillator_config_field, two_speed_enable,
                startup_timer_done, slow_internal_osc,
                fast_internal_osc, secondary_osc, primary_osc};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end
  logic [3:0] osc_tick;
  assign osc_tick = next_filt[3:0] & ~filt[3:0];
  logic ost_done, two_speed;
  logic [2:0] cfg;
  assign ost_done = filt[4];
  assign two_speed = filt[5];
  assign cfg = filt[8:6];

  // ****************************************
  // registers
  // ****************************************
  logic idle_en, ro_en, ro_slp, ro_src, alt_sel, lfs, sec_en;
  logic [2:0] ifs, next_ifs;
  logic [3:0] ro_div, next_ro_div;
  ccs_src_type sel, next_sel, wsel;
  logic next_idle_en, next_ro_en, next_ro_slp, next_ro_src;
  logic next_alt_sel, next_lfs, next_sec_en;
  logic startup_timeout_status, sec_running;
  ccs_sw_type sw_state;
  ccs_pwr_type pwr;
  logic [7:0] next_rdata;
  assign wsel = ccs_src_type'(reg_wdata[1:0]);
  always_comb begin
    next_idle_en = idle_en;
    next_ifs = ifs;
    next_sel = sel;
    {next_ro_en, next_ro_slp, next_ro_src} = {ro_en, ro_slp, ro_src};
    next_ro_div = ro_div;
    {next_alt_sel, next_lfs, next_sec_en} = {alt_sel, lfs, sec_en};
    next_rdata = 8'h00;
    if (reg_wr && reg_addr == CCS_OFS_OSC_CTRL) begin
      if (alt_sel) begin
        next_ro_en = reg_wdata[CCS_RO_EN_BIT];
        next_ro_slp = reg_wdata[CCS_RO_SLP_BIT];
        next_ro_src = reg_wdata[CCS_RO_SRC_BIT];
        next_ro_div = reg_wdata[3:0];
      end else begin
        next_idle_en = reg_wdata[CCS_IDLE_BIT];
        next_ifs = reg_wdata[6:4];
        // reserved code and unenabled secondary leave select alone
        if (wsel != CCS_SRC_RSVD &&
            (wsel != CCS_SRC_SEC || sec_en)) begin
          next_sel = wsel;
        end
      end
    end
    if (reg_wr && reg_addr == CCS_OFS_AUX) begin
      next_alt_sel = reg_wdata[CCS_AUX_ALT_BIT];
      next_lfs = reg_wdata[CCS_AUX_LFS_BIT];
      next_sec_en = reg_wdata[CCS_AUX_SEC_EN_BIT];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        CCS_OFS_OSC_CTRL: begin
          if (alt_sel) begin
            next_rdata = {ro_en, 1'b0, ro_slp, ro_src, ro_div};
          end else begin
            next_rdata = {idle_en, ifs, startup_timeout_status, 1'b1, sel};
          end
        end
        CCS_OFS_AUX: next_rdata = {3'h0, alt_sel, 2'h0, sec_en, lfs};
        CCS_OFS_STATUS: next_rdata = {2'h0, pwr, active_source,
                                      sw_state != CCS_SW_RUN, sec_running};
        default: next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_en <= 1'b0;
      ifs <= CCS_IFS_RESET;
      sel <= CCS_SRC_PRI;
      {ro_en, ro_slp, ro_src} <= 3'h0;
      ro_div <= 4'h0;
      {alt_sel, lfs, sec_en} <= 3'h0;
      reg_rdata <= 8'h00;
    end else begin
      idle_en <= next_idle_en;
      ifs <= next_ifs;
      sel <= next_sel;
      {ro_en, ro_slp, ro_src} <= {next_ro_en, next_ro_slp, next_ro_src};
      ro_div <= next_ro_div;
      {alt_sel, lfs, sec_en} <= {next_alt_sel, next_lfs, next_sec_en};
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // internal postscaler and source ticks
  // ****************************************
  logic [7:0] ps_cnt, ps_mask;
  logic int_tick, pri_tick, old_tick, new_tick;
  always_comb begin
    unique case (ifs)
      3'h7: ps_mask = 8'h00;
      3'h6: ps_mask = 8'h01;
      3'h5: ps_mask = 8'h03;
      3'h4: ps_mask = 8'h07;
      3'h3: ps_mask = 8'h0f;
      3'h2: ps_mask = 8'h1f;
      3'h1: ps_mask = 8'h3f;
      3'h0: ps_mask = 8'hff;
    endcase
  end
  // mask is taken from the live field, so a change acts at once
  assign int_tick = (ifs == CCS_IFS_LOW && !lfs) ? osc_tick[3] :
                    osc_tick[2] && ((ps_cnt & ps_mask) == ps_mask);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ps_cnt <= 8'h00;
    end else if (osc_tick[2]) begin
      ps_cnt <= ps_cnt + 8'h01;
    end
  end
  assign pri_tick = (cfg == CCS_CFG_INT_A || cfg == CCS_CFG_INT_B) ?
                    int_tick : osc_tick[0];
  function automatic logic src_tick(input ccs_src_type s, input logic p,
                                    input logic t, input logic n);
    unique case (s)
      CCS_SRC_PRI: src_tick = p;
      CCS_SRC_SEC: src_tick = t;
      CCS_SRC_INT: src_tick = n;
      CCS_SRC_RSVD: src_tick = 1'b0;
    endcase
  endfunction
  ccs_src_type target;
  assign old_tick = src_tick(active_source, pri_tick, osc_tick[1],
                             int_tick);
  assign new_tick = src_tick(target, pri_tick, osc_tick[1], int_tick);

  // ****************************************
  // glitch-free switch and power modes
  // ****************************************
  ccs_sw_type next_sw_state;
  ccs_pwr_type next_pwr;
  ccs_src_type next_active, next_target;
  logic [1:0] sw_cnt, next_sw_cnt;
  logic next_sys, next_startup_timeout_status, next_sec_running;
  always_comb begin
    next_sw_state = sw_state;
    next_active = active_source;
    next_target = target;
    next_sw_cnt = sw_cnt;
    next_pwr = pwr;
    unique case (sw_state)
      CCS_SW_RUN: begin
        if (sel != active_source) begin
          next_target = sel;
          next_sw_cnt = 2'h0;
          next_sw_state = CCS_SW_OLD;
        end
      end
      CCS_SW_OLD: begin
        if (old_tick) begin
          next_sw_cnt = sw_cnt + 2'h1;
          if (sw_cnt == CCS_OLD_TICKS - 2'h1) begin
            next_sw_cnt = 2'h0;
            next_sw_state = CCS_SW_NEW;
          end
        end
      end
      CCS_SW_NEW: begin
        // a secondary that never starts stalls here
        if (new_tick) begin
          next_sw_cnt = sw_cnt + 2'h1;
          if (sw_cnt == CCS_NEW_TICKS - 2'h1) begin
            next_sw_cnt = 2'h0;
            next_active = target;
            next_sw_state = CCS_SW_RUN;
          end
        end
      end
      default: next_sw_state = CCS_SW_RUN;
    endcase
    if (pwr == CCS_PWR_ACTIVE && sleep_cmd) begin
      next_pwr = idle_en ? CCS_PWR_IDLE : CCS_PWR_SLEEP;
    end else if (wake_cmd) begin
      next_pwr = CCS_PWR_ACTIVE;
    end
    next_sys = sw_state == CCS_SW_RUN && old_tick &&
               pwr != CCS_PWR_SLEEP;
    next_startup_timeout_status = active_source == CCS_SRC_PRI &&
                (ost_done || !two_speed);
    next_sec_running = active_source == CCS_SRC_SEC &&
                       sw_state == CCS_SW_RUN;
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_state <= CCS_SW_RUN;
      active_source <= CCS_SRC_PRI;
      target <= CCS_SRC_PRI;
      sw_cnt <= 2'h0;
      pwr <= CCS_PWR_ACTIVE;
      {sys_clk_en, cpu_clk_en, periph_clk_en, watchdog_clk_en} <= 4'h0;
      {startup_timeout_status, sec_running} <= 2'h0;
    end else begin
      sw_state <= next_sw_state;
      active_source <= next_active;
      target <= next_target;
      sw_cnt <= next_sw_cnt;
      pwr <= next_pwr;
      {sys_clk_en, periph_clk_en} <= {2{next_sys}};
      cpu_clk_en <= next_sys && pwr == CCS_PWR_ACTIVE;
      watchdog_clk_en <= osc_tick[3];
      {startup_timeout_status, sec_running} <= {next_startup_timeout_status, next_sec_running};
    end
  end

  // ****************************************
  // reference clock output
  // ****************************************
  logic base_tick, ro_run, next_ro_level;
  logic [14:0] ro_cnt, next_ro_cnt, ro_half;
  assign base_tick = ro_src ? osc_tick[0] : next_sys;
  // in sleep only an external primary keeps oscillating
  assign ro_run = ro_en && (pwr != CCS_PWR_SLEEP ||
                  (ro_slp && ro_src && cfg != CCS_CFG_INT_A &&
                   cfg != CCS_CFG_INT_B));
  assign ro_half = 15'h0001 << (ro_div - 4'h1);
  always_comb begin
    next_ro_cnt = ro_cnt;
    next_ro_level = refout_pin;
    if (!ro_run) begin
      next_ro_cnt = 15'h0000;
      next_ro_level = 1'b0;
    end else if (ro_div == 4'h0) begin
      next_ro_level = base_tick;
    end else if (base_tick) begin
      // a smaller divisor must not wait for the count to wrap
      if (ro_cnt >= ro_half - 15'h0001) begin
        next_ro_cnt = 15'h0000;
        next_ro_level = !refout_pin;
      end else begin
        next_ro_cnt = ro_cnt + 15'h0001;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ro_cnt <= 15'h0000;
      refout_pin <= 1'b0;
      refout_pin_oe_b <= 1'b1;
    end else begin
      ro_cnt <= next_ro_cnt;
      refout_pin <= next_ro_level;
      refout_pin_oe_b <= !ro_en;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_sel_reset;
    $rose(rst_b) |-> sel == CCS_SRC_PRI && ifs == CCS_IFS_RESET;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("select or frequency wrong after reset");
  property p_sel_write;
    reg_wr && reg_addr == CCS_OFS_OSC_CTRL && !alt_sel &&
    wsel == CCS_SRC_INT |=> sel == CCS_SRC_INT;
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("internal select not taken");
  property p_sec_blocked;
    reg_wr && reg_addr == CCS_OFS_OSC_CTRL && !alt_sel &&
    wsel == CCS_SRC_SEC && !sec_en |=> $stable(sel);
  endproperty
  a_sec_blocked: assert property (p_sec_blocked)
    else $error("secondary selected while disabled");
  property p_pause;
    sw_state != CCS_SW_RUN |=> !sys_clk_en;
  endproperty
  a_pause: assert property (p_pause)
    else $error("system clock ran during switch");
  property p_status_excl;
    !(startup_timeout_status && sec_running);
  endproperty
  a_status_excl: assert property (p_status_excl)
    else $error("both source status bits set");
  property p_unused_one;
    reg_rd && reg_addr == CCS_OFS_OSC_CTRL && !alt_sel
    |=> reg_rdata[CCS_UNUSED_BIT];
  endproperty
  a_unused_one: assert property (p_unused_one)
    else $error("unused bit read as zero");
  property p_alt_read;
    reg_rd && reg_addr == CCS_OFS_OSC_CTRL && alt_sel
    |=> reg_rdata == {$past(ro_en), 1'b0, $past(ro_slp),
                      $past(ro_src), $past(ro_div)};
  endproperty
  a_alt_read: assert property (p_alt_read)
    else $error("alternate register read wrong");
  property p_idle;
    pwr == CCS_PWR_ACTIVE && sleep_cmd && !wake_cmd
    |=> pwr == ($past(idle_en) ? CCS_PWR_IDLE : CCS_PWR_SLEEP);
  endproperty
  a_idle: assert property (p_idle)
    else $error("wrong power mode on sleep");
  property p_ro_off;
    !ro_en |=> !refout_pin && refout_pin_oe_b;
  endproperty
  a_ro_off: assert property (p_ro_off)
    else $error("reference output active while disabled");
  property p_wdt;
    osc_tick[3] |=> watchdog_clk_en;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog tick lost");
endmodule // ccs_clock_switch
`default_nettype wire

// *** tb/ccs_clock_switch_test.sv ***
// self-checking bench for the clock source switch and reference output
// assumes the oscillators are made here as slow square waves toggled on core_clk
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_switch_test;
  import ccs_pkg::*;
  // ****************************************
  // signals and design
  // ****************************************
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic primary_osc = 1'b0;
  logic secondary_osc = 1'b0;
  logic fast_internal_osc = 1'b0;
  logic slow_internal_osc = 1'b0;
  logic startup_timer_done = 1'b0;
  logic two_speed_enable = 1'b0;
  logic [2:0] oscillator_config_field = 3'h2;
  logic sleep_cmd = 1'b0;
  logic wake_cmd = 1'b0;
  logic sys_clk_en, cpu_clk_en, periph_clk_en, watchdog_clk_en;
  logic refout_pin, refout_pin_oe_b;
  ccs_src_type active_source;
  int num_errors = 0;
  int cmp_count = 0;
  int osc_cnt = 0;
  int per, hi, t, p;
  logic [7:0] rv;

  ccs_clock_switch dut (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .primary_osc(primary_osc),
    .secondary_osc(secondary_osc), .fast_internal_osc(fast_internal_osc),
    .slow_internal_osc(slow_internal_osc),
    .startup_timer_done(startup_timer_done),
    .two_speed_enable(two_speed_enable),
    .oscillator_config_field(oscillator_config_field),
    .sleep_cmd(sleep_cmd), .wake_cmd(wake_cmd), .sys_clk_en(sys_clk_en),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .watchdog_clk_en(watchdog_clk_en), .active_source(active_source),
    .refout_pin(refout_pin), .refout_pin_oe_b(refout_pin_oe_b));

  // ****************************************
  // clocks: periods 10, 14, 8, 20 core cycles
  // ****************************************
  always #4 core_clk = ~core_clk;
  // oscillators locked to core_clk so tick periods are exact
  always @(posedge core_clk) begin
    osc_cnt <= osc_cnt + 1;
    if (osc_cnt % 5 == 4) primary_osc <= ~primary_osc;
    if (osc_cnt % 7 == 6) secondary_osc <= ~secondary_osc;
    if (osc_cnt % 4 == 3) fast_internal_osc <= ~fast_internal_osc;
    if (osc_cnt % 10 == 9) slow_internal_osc <= ~slow_internal_osc;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
      num_errors++;
    end
  endtask

  // one idle edge after each strobe so no strobe is assigned twice
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
  endtask

  task automatic pwr(input logic slp);
    @(posedge core_clk);
    if (slp) sleep_cmd <= 1'b1;
    else wake_cmd <= 1'b1;
    @(posedge core_clk);
    sleep_cmd <= 1'b0;
    wake_cmd <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return sys_clk_en;
      1: return cpu_clk_en;
      2: return periph_clk_en;
      3: return watchdog_clk_en;
      default: return refout_pin;
    endcase
  endfunction

  task automatic wrise(input int s);
    int n;
    n = 0;
    while (sig(s) !== 1'b0 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    while (sig(s) !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  // first interval may be cut short by a setting change, so skip it
  task automatic meas(input int s, output int pr, output int h);
    wrise(s);
    wrise(s);
    pr = 0;
    h = 0;
    while (sig(s) === 1'b1 && pr < 5000) begin
      @(negedge core_clk);
      pr++;
      h++;
    end
    while (sig(s) !== 1'b1 && pr < 5000) begin
      @(negedge core_clk);
      pr++;
    end
  endtask

  task automatic count(input int s, input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(negedge core_clk);
      if (sig(s) === 1'b1) c++;
    end
  endtask

  task automatic sw(input logic [7:0] d, input ccs_src_type s);
    wr(2'h0, d);
    t = 0;
    p = 0;
    while (active_source !== s && t < 3000) begin
      @(negedge core_clk);
      t++;
      if (t > 3 && sys_clk_en === 1'b1) p++;
    end
  endtask

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #800000;
    num_errors++;
    finish_test();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge core_clk);
    rchk(2'h0, 8'h6c);
    chk("active_source", CCS_SRC_PRI, active_source);
    wr(2'h3, 8'hff);
    rchk(2'h3, 8'h00);
    two_speed_enable <= 1'b1;
    repeat (8) @(posedge core_clk);
    rchk(2'h0, 8'h64);
    startup_timer_done <= 1'b1;
    repeat (8) @(posedge core_clk);
    rchk(2'h0, 8'h6c);
    meas(0, per, hi);
    chk("sys_period", 10, per);
    oscillator_config_field <= 3'h0;
    meas(0, per, hi);
    chk("sys_period", 16, per);
    oscillator_config_field <= 3'h1;
    meas(0, per, hi);
    chk("sys_period", 16, per);
    oscillator_config_field <= 3'h2;
    // secondary select refused while its oscillator is off
    wr(2'h1, 8'h00);
    wr(2'h0, 8'h61);
    repeat (60) @(posedge core_clk);
    rchk(2'h0, 8'h6c);
    wr(2'h1, 8'h02);
    sw(8'h61, CCS_SRC_SEC);
    chk("active_source", CCS_SRC_SEC, active_source);
    rchk(2'h0, 8'h65);
    rchk(2'h2, 8'h05);
    wr(2'h0, 8'h62);
    rchk(2'h0, 8'h65);
    sw(8'h73, CCS_SRC_INT);
    chk("active_source", CCS_SRC_INT, active_source);
    chk("switch_long", 1, t >= 24);
    chk("switch_pulses", 0, p);
    rchk(2'h0, 8'h77);
    for (int f = 7; f >= 1; f--) begin
      wr(2'h0, {1'b0, f[2:0], 4'h3});
      meas(0, per, hi);
      chk("sys_period", 8 << (7 - f), per);
    end
    wr(2'h0, 8'h03);
    meas(0, per, hi);
    chk("sys_period", 20, per);
    wr(2'h1, 8'h03);
    meas(0, per, hi);
    chk("sys_period", 2048, per);
    wr(2'h1, 8'h02);
    wr(2'h0, 8'he3);
    pwr(1'b1);
    rchk(2'h2, 8'h1c);
    count(1, 64, p);
    chk("cpu_pulses", 0, p);
    count(2, 64, p);
    chk("periph_pulses", 4, p);
    pwr(1'b0);
    rchk(2'h2, 8'h0c);
    wr(2'h0, 8'h63);
    pwr(1'b1);
    rchk(2'h2, 8'h2c);
    count(2, 64, p);
    chk("periph_pulses", 0, p);
    meas(3, per, hi);
    chk("watchdog_period", 20, per);
    pwr(1'b0);
    // reference output through the alternate view
    wr(2'h1, 8'h12);
    rchk(2'h0, 8'h00);
    wr(2'h0, 8'hff);
    rchk(2'h0, 8'hbf);
    wr(2'h0, 8'h90);
    meas(4, per, hi);
    chk("ref_period", 10, per);
    for (int n = 1; n <= 3; n++) begin
      wr(2'h0, 8'h90 | n[7:0]);
      meas(4, per, hi);
      chk("ref_period", 10 << n, per);
      chk("ref_high", 5 << n, hi);
      chk("ref_oe_b", 0, refout_pin_oe_b);
    end
    wr(2'h0, 8'h81);
    meas(4, per, hi);
    chk("ref_period", 32, per);
    wr(2'h0, 8'h01);
    repeat (4) @(posedge core_clk);
    chk("ref_oe_b", 1, refout_pin_oe_b);
    count(4, 40, p);
    chk("ref_pulses", 0, p);
    wr(2'h0, 8'hb1);
    pwr(1'b1);
    meas(4, per, hi);
    chk("ref_sleep_period", 20, per);
    pwr(1'b0);
    // an internal primary stops in sleep, so the output must stop too
    oscillator_config_field <= 3'h1;
    pwr(1'b1);
    count(4, 60, p);
    chk("ref_int_sleep_pulses", 0, p);
    pwr(1'b0);
    oscillator_config_field <= 3'h2;
    wr(2'h0, 8'h91);
    pwr(1'b1);
    count(4, 60, p);
    chk("ref_sleep_pulses", 0, p);
    pwr(1'b0);
    // second reset in mid-run from the internal source
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("active_source", CCS_SRC_PRI, active_source);
    rchk(2'h0, 8'h6c);
    finish_test();
  end
endmodule // ccs_clock_switch_test
`default_nettype wire
